// ### core/bpp_port.sv
// eight-pin basic parallel port with register bus slave
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R1: every pin carries either general-purpose i/o or an on-chip module function, chosen per pin.
// R2: the port has data, direction and select registers of 8 bits, bit n steering only pin n.
// R3: in general-purpose mode the direction bit decides whether the pin is driven or left as input.
// R4: in special mode the module sets the pin direction and the direction bit is ignored.
// R5: in special mode a read of the data bit returns the present pin level.
// R6: as a general-purpose input a read of the data bit returns the present pin level.
// R7: as a general-purpose output the pin is driven high for data bit 1 and low for data bit 0.
// R8: a select bit of 0 hands the pin to its module, a select bit of 1 makes it general-purpose.
// R9: an output-only module function holds its output enable on and drives the pin with its data.
// R10: an input-only module function keeps its output enable off and receives the pin level.
// R11: pin 0 carries the serial master transmit line and pin 1 its receive line when selected.
// R12: software should load the data latch before switching a pin from module to general-purpose.
// R13: bus writes update the registers at the completing edge, and reset restores their values.
module bpp_port
    import bpp_pkg::*;
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [BPP_ADDR_W-1:0] paddr,
    input  wire logic [BPP_DATA_W-1:0] pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [BPP_DATA_W-1:0] prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic [BPP_PINS-1:0]   pin_in,
    output logic      [BPP_PINS-1:0]   pin_out,
    output logic      [BPP_PINS-1:0]   pin_oe,
    input  wire logic [BPP_PINS-1:0]   mod_out,
    input  wire logic [BPP_PINS-1:0]   mod_oe,
    output logic      [BPP_PINS-1:0]   mod_in,
    input  wire logic                  spim_txd,
    output logic                       spim_rxd
);

    // configuration registers
    logic [BPP_PINS-1:0]   data_q;
    logic [BPP_PINS-1:0]   data_d;
    logic [BPP_PINS-1:0]   dir_q;
    logic [BPP_PINS-1:0]   dir_d;
    logic [BPP_PINS-1:0]   sel_q;
    logic [BPP_PINS-1:0]   sel_d;

    // bus answer registers
    logic [BPP_DATA_W-1:0] prdata_q;
    logic [BPP_DATA_W-1:0] prdata_d;
    logic                  pslverr_q;
    logic                  pslverr_d;

    // decode results
    logic                  setup_rd;
    logic                  setup_any;
    logic [1:0]            reg_idx;
    logic                  wr_data;
    logic                  wr_dir;
    logic                  wr_sel;

    // pin side
    logic [BPP_PINS-1:0]   rd_bits;
    logic [BPP_PINS-1:0]   rd_byte;
    logic [BPP_PINS-1:0]   mux_out;
    logic [BPP_PINS-1:0]   mux_oe;
    logic [BPP_PINS-1:0]   mux_in;

    // bus decode
    bpp_apb_dec u_dec (
        .psel      (psel),
        .penable   (penable),
        .pwrite    (pwrite),
        .paddr     (paddr),
        .pstrb     (pstrb),
        .setup_rd  (setup_rd),
        .setup_any (setup_any),
        .reg_idx   (reg_idx),
        .wr_data   (wr_data),
        .wr_dir    (wr_dir),
        .wr_sel    (wr_sel)
    );

    // next register values: a strobe loads the low byte of the write data
    assign data_d = wr_data ? pwdata[BPP_PINS-1:0] : data_q; // R2 R13
    assign dir_d  = wr_dir  ? pwdata[BPP_PINS-1:0] : dir_q;  // R2 R13
    assign sel_d  = wr_sel  ? pwdata[BPP_PINS-1:0] : sel_q;  // R2 R13

    // configuration registers, reset to general-purpose inputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_q <= BPP_DATA_RST; // R13
            dir_q  <= BPP_DIR_RST;  // R13
            sel_q  <= BPP_SEL_RST;  // R13
        end else begin
            data_q <= data_d;
            dir_q  <= dir_d;
            sel_q  <= sel_d;
        end
    end

    // serial master lines replace the module lanes of pins 0 and 1
    always_comb begin
        mux_out                  = mod_out;
        mux_oe                   = mod_oe;
        mux_out[BPP_SPIM_TX_BIT] = spim_txd; // R9 R11
        mux_oe[BPP_SPIM_TX_BIT]  = 1'b1;     // R9 R11
        mux_oe[BPP_SPIM_RX_BIT]  = 1'b0;     // R10 R11
    end

    // per-pin function, direction and read-back selection
    bpp_pin_mux u_mux (
        .sel     (sel_q),
        .dir     (dir_q),
        .data    (data_q),
        .mod_out (mux_out),
        .mod_oe  (mux_oe),
        .pin_in  (pin_in),
        .pin_out (pin_out),
        .pin_oe  (pin_oe),
        .rd_bits (rd_bits),
        .mod_in  (mux_in)
    );

    // module-facing inputs, receive line taken straight from pin 1
    assign mod_in   = mux_in;
    assign spim_rxd = mux_in[BPP_SPIM_RX_BIT]; // R10 R11

    // read selection, data reads show live pin levels except on general-purpose outputs
    assign rd_byte = (reg_idx == BPP_REG_DATA) ? rd_bits : // R5 R6
                     (reg_idx == BPP_REG_DIR)  ? dir_q   :
                     (reg_idx == BPP_REG_SEL)  ? sel_q   : '0;

    // answer captured in the setup cycle, upper bits read as zero
    assign prdata_d  = setup_rd  ? {{(BPP_DATA_W-BPP_PINS){1'b0}}, rd_byte} : prdata_q;
    assign pslverr_d = setup_any ? (reg_idx == BPP_REG_NONE) : pslverr_q;

    // bus answer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q  <= '0;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q  <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    // zero-wait slave: every access phase completes at its first edge
    assign pready  = 1'b1;
    assign prdata  = prdata_q;
    assign pslverr = pslverr_q && psel && penable;

    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // helper: pins in special mode or gpio input, where the pin level is read
    logic [BPP_PINS-1:0] live_mask;
    assign live_mask = ~(sel_q & dir_q);

    // helper: pins whose module lanes reach the pins unchanged, serial master pins excluded
    logic [BPP_PINS-1:0] lane_mask;
    always_comb begin
        lane_mask                  = '1;
        lane_mask[BPP_SPIM_TX_BIT] = 1'b0;
        lane_mask[BPP_SPIM_RX_BIT] = 1'b0;
    end

    // write access to one register offset with the low lane enabled
    sequence s_wr_access(logic [11:0] off);
        psel && penable && pwrite && pstrb[0] && (paddr == off);
    endsequence

    // read setup on the data register followed by its access phase
    sequence s_rd_data;
        psel && !penable && !pwrite && (paddr == BPP_OFF_DATA) ##1 psel && penable;
    endsequence

    // read setup followed by its access phase on a given address
    sequence s_rd_setup(logic [11:0] off);
        psel && !penable && !pwrite && (paddr == off) ##1 psel && penable;
    endsequence

    a_data_write_update: assert property ( // R13
        s_wr_access(BPP_OFF_DATA) |=> (data_q == $past(pwdata[BPP_PINS-1:0])))
        else $error("data latch did not take the written byte");

    a_dir_write_update: assert property ( // R2
        s_wr_access(BPP_OFF_DIR) |=> (dir_q == $past(pwdata[BPP_PINS-1:0])) && $stable(sel_q))
        else $error("direction write wrong or disturbed select");

    a_sel_hold_idle: assert property ( // R13
        !(psel && penable && pwrite) |=> $stable(sel_q) && $stable(dir_q) && $stable(data_q))
        else $error("register changed without a write");

    a_reset_values: assert property ( // R13
        $rose(presetn) |-> (sel_q == BPP_SEL_RST) && (dir_q == BPP_DIR_RST) && (data_q == BPP_DATA_RST))
        else $error("registers not at reset values after reset");

    a_gpio_out_drive: assert property ( // R3
        ((pin_oe & sel_q) == (sel_q & dir_q)) && (((pin_out ^ data_q) & sel_q & dir_q) == '0))
        else $error("general-purpose output not driven from the latch");

    a_gpio_level_out: assert property ( // R7
        s_wr_access(BPP_OFF_DATA)
            |=> (((pin_out ^ $past(pwdata[BPP_PINS-1:0])) & sel_q & dir_q) == '0) &&
                (((pin_oe ^ dir_q) & sel_q) == '0))
        else $error("written level did not reach the output pin");

    a_special_direction: assert property ( // R4
        ((pin_oe ^ mux_oe) & ~sel_q) == '0)
        else $error("special-mode pin direction not set by its module");

    a_read_live_level: assert property ( // R5
        s_rd_data |-> ((prdata[BPP_PINS-1:0] ^ $past(pin_in)) & $past(live_mask)) == '0)
        else $error("data read did not show the pin level");

    a_read_input_upper: assert property ( // R6
        s_rd_data |-> (prdata[BPP_DATA_W-1:BPP_PINS] == '0) && pready && !pslverr)
        else $error("data read answer malformed");

    a_spim_tx_path: assert property ( // R9
        (sel_q[BPP_SPIM_TX_BIT] == BPP_SEL_SPECIAL) |-> pin_oe[BPP_SPIM_TX_BIT] &&
            (pin_out[BPP_SPIM_TX_BIT] == spim_txd))
        else $error("transmit pin not driven by the serial master");

    a_spim_rx_path: assert property ( // R10
        (sel_q[BPP_SPIM_RX_BIT] == BPP_SEL_SPECIAL) |-> !pin_oe[BPP_SPIM_RX_BIT] &&
            (spim_rxd == pin_in[BPP_SPIM_RX_BIT]))
        else $error("receive pin driven or not routed to the serial master");

    a_sel_mode_switch: assert property ( // R8
        s_wr_access(BPP_OFF_SEL) ##1 ($past(pwdata[BPP_SPIM_TX_BIT]) == BPP_SEL_SPECIAL)
            |-> pin_oe[BPP_SPIM_TX_BIT] && (pin_out[BPP_SPIM_TX_BIT] == spim_txd)) // R11
        else $error("clearing the select bit did not hand the pin to its module");

    a_unmapped_error: assert property ( // R1
        psel && !penable && (paddr != BPP_OFF_DATA) && (paddr != BPP_OFF_DIR) &&
            (paddr != BPP_OFF_SEL) |=> pslverr ##1 $stable(data_q) && $stable(dir_q) && $stable(sel_q))
        else $error("unmapped access not refused");

    // bus access checks
    a_strb_ignored: assert property ( // R13
        psel && penable && pwrite && !pstrb[0] |=> $stable(data_q) && $stable(dir_q) && $stable(sel_q))
        else $error("write with its byte lane off changed a register");

    a_mapped_no_error: assert property ( // R13
        psel && !penable && (reg_idx != BPP_REG_NONE) |=> !pslverr)
        else $error("error flagged on a mapped register");

    a_unmapped_read_zero: assert property ( // R2
        psel && !penable && !pwrite && (reg_idx == BPP_REG_NONE) ##1 psel && penable
            |-> (prdata == '0) && pslverr)
        else $error("unmapped read returned data or no error");

    a_prdata_hold: assert property ( // R13
        !(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data changed outside a read setup");

    a_read_dir_value: assert property ( // R2
        s_rd_setup(BPP_OFF_DIR) |-> (prdata[BPP_PINS-1:0] == $past(dir_q)))
        else $error("direction read did not return the register");

    a_read_sel_value: assert property ( // R8
        s_rd_setup(BPP_OFF_SEL) |-> (prdata[BPP_PINS-1:0] == $past(sel_q)))
        else $error("select read did not return the register");

    a_read_out_latch: assert property ( // R7
        s_rd_data |-> ((prdata[BPP_PINS-1:0] ^ $past(data_q)) & ~$past(live_mask)) == '0)
        else $error("data read of an output pin did not return the latch");

    a_sel_write_update: assert property ( // R8
        s_wr_access(BPP_OFF_SEL) |=> (sel_q == $past(pwdata[BPP_PINS-1:0])))
        else $error("select register did not take the written byte");

    // pin checks
    a_special_out_lane: assert property ( // R1
        ((pin_out ^ mod_out) & ~sel_q & lane_mask) == '0)
        else $error("special-mode pin not driven with its module data");

    a_special_oe_lane: assert property ( // R4
        ((pin_oe ^ mod_oe) & ~sel_q & lane_mask) == '0)
        else $error("special-mode pin enable not taken from its module");

    a_tx_gpio_release: assert property ( // R3
        (sel_q[BPP_SPIM_TX_BIT] == BPP_SEL_GPIO)
            |-> (pin_oe[BPP_SPIM_TX_BIT] == dir_q[BPP_SPIM_TX_BIT]) &&
                (pin_out[BPP_SPIM_TX_BIT] == data_q[BPP_SPIM_TX_BIT]))
        else $error("transmit pin in general-purpose mode still follows the serial master");

    a_rx_gpio_drive: assert property ( // R7
        (sel_q[BPP_SPIM_RX_BIT] == BPP_SEL_GPIO) && (dir_q[BPP_SPIM_RX_BIT] == BPP_DIR_OUT)
            |-> pin_oe[BPP_SPIM_RX_BIT] && (pin_out[BPP_SPIM_RX_BIT] == data_q[BPP_SPIM_RX_BIT]))
        else $error("receive pin as general-purpose output not driven from the latch");

endmodule : bpp_port

`default_nettype wire

// ### core/bpp_pkg.sv
// shared constants of the basic parallel port block
package bpp_pkg;

    // port geometry
    localparam int          BPP_PINS       = 8;
    localparam int          BPP_ADDR_W     = 12;
    localparam int          BPP_DATA_W     = 32;

    // register byte offsets on the bus
    localparam logic [11:0] BPP_OFF_DATA   = 12'h000;
    localparam logic [11:0] BPP_OFF_DIR    = 12'h004;
    localparam logic [11:0] BPP_OFF_SEL    = 12'h008;

    // register reset values: every pin a general-purpose input, latch clear
    localparam logic [7:0]  BPP_DATA_RST   = 8'h00;
    localparam logic [7:0]  BPP_DIR_RST    = 8'h00;
    localparam logic [7:0]  BPP_SEL_RST    = 8'hff;

    // function-select encoding per pin
    localparam logic        BPP_SEL_SPECIAL = 1'b0;
    localparam logic        BPP_SEL_GPIO    = 1'b1;

    // direction encoding per pin
    localparam logic        BPP_DIR_IN     = 1'b0;
    localparam logic        BPP_DIR_OUT    = 1'b1;

    // pins that carry the serial master lines
    localparam int          BPP_SPIM_TX_BIT = 0;
    localparam int          BPP_SPIM_RX_BIT = 1;

    // register index codes for the read multiplexer
    localparam logic [1:0]  BPP_REG_DATA   = 2'h0;
    localparam logic [1:0]  BPP_REG_DIR    = 2'h1;
    localparam logic [1:0]  BPP_REG_SEL    = 2'h2;
    localparam logic [1:0]  BPP_REG_NONE   = 2'h3;

endpackage : bpp_pkg

// ### core/bpp_apb_dec.sv
// address decode and strobes of the register bus slave
`timescale 1ns/1ps
`default_nettype none

module bpp_apb_dec
    import bpp_pkg::*;
(
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [BPP_ADDR_W-1:0] paddr,
    input  wire logic [3:0]            pstrb,
    output logic                       setup_rd,
    output logic                       setup_any,
    output logic [1:0]                 reg_idx,
    output logic                       wr_data,
    output logic                       wr_dir,
    output logic                       wr_sel
);

    logic access_wr;

    // register index from the address, unmapped words get the spare code
    assign reg_idx = (paddr == BPP_OFF_DATA) ? BPP_REG_DATA :
                     (paddr == BPP_OFF_DIR)  ? BPP_REG_DIR  :
                     (paddr == BPP_OFF_SEL)  ? BPP_REG_SEL  : BPP_REG_NONE;

    // phase qualifiers
    assign setup_any = psel && !penable;
    assign setup_rd  = setup_any && !pwrite;
    assign access_wr = psel && penable && pwrite && pstrb[0];

    // one write strobe per register, only the low byte lane carries data
    assign wr_data = access_wr && (reg_idx == BPP_REG_DATA);
    assign wr_dir  = access_wr && (reg_idx == BPP_REG_DIR);
    assign wr_sel  = access_wr && (reg_idx == BPP_REG_SEL);

endmodule : bpp_apb_dec

`default_nettype wire

// ### core/bpp_pin_mux.sv
// per-pin multiplexer between general-purpose logic and an on-chip module
`timescale 1ns/1ps
`default_nettype none

module bpp_pin_mux
    import bpp_pkg::*;
(
    input  wire logic [BPP_PINS-1:0] sel,
    input  wire logic [BPP_PINS-1:0] dir,
    input  wire logic [BPP_PINS-1:0] data,
    input  wire logic [BPP_PINS-1:0] mod_out,
    input  wire logic [BPP_PINS-1:0] mod_oe,
    input  wire logic [BPP_PINS-1:0] pin_in,
    output logic      [BPP_PINS-1:0] pin_out,
    output logic      [BPP_PINS-1:0] pin_oe,
    output logic      [BPP_PINS-1:0] rd_bits,
    output logic      [BPP_PINS-1:0] mod_in
);

    // one identical cell per pin
    genvar i;
    generate
        for (i = 0; i < BPP_PINS; i++) begin : g_pin
            wire gpio_w   = (sel[i] == BPP_SEL_GPIO);        // R1 R8
            wire drive_w  = gpio_w && (dir[i] == BPP_DIR_OUT);
            // direction from the module in special mode, from the register otherwise
            assign pin_oe[i]  = gpio_w ? drive_w : mod_oe[i];  // R3 R4
            // data from the latch in gpio mode, from the module otherwise
            assign pin_out[i] = gpio_w ? data[i] : mod_out[i]; // R7
            // the latch only when driving as gpio output, else the pin level
            assign rd_bits[i] = drive_w ? data[i] : pin_in[i]; // R5 R6
            // pin level always offered to the module
            assign mod_in[i]  = pin_in[i];                     // R10
        end
    endgenerate

endmodule : bpp_pin_mux

`default_nettype wire

// ### tb/bpp_pin_model.sv
// board-side model of the port pins: resolves the wire level seen by the device
`timescale 1ns/1ps
`default_nettype none

module bpp_pin_model
    import bpp_pkg::*;
(
    input  wire logic                pclk,
    input  wire logic [BPP_PINS-1:0] pin_out,
    input  wire logic [BPP_PINS-1:0] pin_oe,
    input  wire logic [BPP_PINS-1:0] ext_val,
    input  wire logic [BPP_PINS-1:0] ext_oe,
    output logic      [BPP_PINS-1:0] pin_in
);
    logic [BPP_PINS-1:0] float_q = 8'h5a;

    // undriven pins carry a changing pattern, so no stale level passes as valid
    always_ff @(posedge pclk) begin
        float_q <= ~float_q;
    end

    // device drive wins, then the external driver, else the floating pattern
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val) | (~pin_oe & ~ext_oe & float_q);
endmodule : bpp_pin_model

`default_nettype wire

// ### tb/basic_parallel_port_mux_tb.sv
// self-checking testbench of the basic parallel port
`timescale 1ns/1ps
`default_nettype none

module basic_parallel_port_mux_tb
    import bpp_pkg::*;
;
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr, spim_txd, spim_rxd;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [3:0]  pstrb;
    logic [7:0]  pin_in, pin_out, pin_oe, mod_out, mod_oe, mod_in, ext_val, ext_oe;
    logic        erv;
    int          fails = 0, num_checks = 0, cyc = 0;

    always #12.5 pclk = ~pclk;

    bpp_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .mod_out(mod_out),
        .mod_oe(mod_oe), .mod_in(mod_in), .spim_txd(spim_txd), .spim_rxd(spim_rxd));

    bpp_pin_model pins (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
        .ext_oe(ext_oe), .pin_in(pin_in));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one apb transfer: setup, then access until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] wd, input logic [3:0] st);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= {24'h000000, wd}; pstrb <= st;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task automatic wreg(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 4'h1);
    endtask : wreg

    task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00, 4'h0);
        chk(rdv, {24'h000000, exp});
        chk(erv, 0);
    endtask : rchk

    // reset values, and input pins read back their level
    task automatic t_reset();
        rchk(BPP_OFF_DATA, 8'h3e);
        rchk(BPP_OFF_DIR, BPP_DIR_RST);
        rchk(BPP_OFF_SEL, BPP_SEL_RST);
        @(negedge pclk);
        chk(pin_oe, 0);
    endtask : t_reset

    // mixed gpio outputs and inputs
    task automatic t_gpio();
        wreg(BPP_OFF_DATA, 8'h9a);
        wreg(BPP_OFF_DIR, 8'hc3);
        ext_oe <= 8'h3c;
        @(negedge pclk);
        chk(pin_oe, 8'hc3);
        chk(pin_out & pin_oe, 8'h82);
        rchk(BPP_OFF_DATA, 8'hbe);
        wreg(BPP_OFF_DATA, 8'h65);
        @(negedge pclk);
        chk(pin_out & pin_oe, 8'h41);
    endtask : t_gpio

    // all pins handed to modules, direction register ignored
    task automatic t_special();
        mod_oe <= 8'ha4; mod_out <= 8'he6; spim_txd <= 1'b1;
        wreg(BPP_OFF_SEL, {8{BPP_SEL_SPECIAL}});
        wreg(BPP_OFF_DIR, 8'hff);
        ext_oe <= 8'h5a;
        @(negedge pclk);
        chk(pin_oe, 8'ha5);
        chk(pin_out & pin_oe, 8'ha5);
        chk(mod_in, 8'hbf);
        chk(spim_rxd, 1'b1);
        rchk(BPP_OFF_DATA, 8'hbf);
        @(posedge pclk);
        spim_txd <= 1'b0;
        @(negedge pclk);
        chk(pin_out[0], 1'b0);
        wreg(BPP_OFF_DATA, 8'h41);
        wreg(BPP_OFF_SEL, {8{BPP_SEL_GPIO}});
        ext_oe <= 8'h00;
        @(negedge pclk);
        chk(pin_oe, 8'hff);
        chk(pin_out, 8'h41);
    endtask : t_special

    // unmapped address and a write with its byte strobe off
    task automatic t_refuse();
        apb(1'b1, 12'h00c, 8'h77, 4'h1);
        chk(erv, 1'b1);
        apb(1'b0, 12'h00c, 8'h00, 4'h0);
        chk(erv, 1'b1);
        chk(rdv, 0);
        apb(1'b1, BPP_OFF_DIR, 8'h00, 4'h0);
        rchk(BPP_OFF_DIR, 8'hff);
    endtask : t_refuse

    // second reset in mid-run restores the registers
    task automatic t_rereset();
        @(posedge pclk);
        presetn <= 1'b0;
        @(negedge pclk);
        chk(pin_oe, 0);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rchk(BPP_OFF_SEL, BPP_SEL_RST);
        rchk(BPP_OFF_DIR, BPP_DIR_RST);
    endtask : t_rereset

    // cut a hang short
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            wrap_up();
        end
    end

    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
        pwdata = 32'h00000000; pstrb = 4'h0; mod_out = 8'h00; mod_oe = 8'h00; spim_txd = 1'b0;
        ext_val = 8'h3e; ext_oe = 8'hff;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_gpio();
        t_special();
        t_refuse();
        t_rereset();
        wrap_up();
    end
endmodule : basic_parallel_port_mux_tb

`default_nettype wire
